// [src/ppf_top.v]
// Cookware timer, period guard, phase protection and fault trigger front end
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "ppf_consts.vh"
module ppf_top #(
    parameter [16:0] WAIT_BASE_CYCLES = `PPF_WAIT_BASE
) (
    input wire mclk_in,
    input wire rst_in,
    input wire current_cmp0_out_in,
    input wire current_cmp1_out_in,
    input wire [6:0] fault_cmp_out_in,
    input wire bridge_out_a_in,
    input wire bridge_out_b_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    output reg [11:0] pwm_period_out,
    output reg pwm_run_out,
    output reg pwm_safe_out,
    output reg capture_irq_out,
    output reg phase_protect_irq_out,
    output reg fault_irq_out
);
    localparam S_IDLE = 2'd0;
    localparam S_RUN = 2'd1;

    reg [`PPF_CTRL_W-1:0] ctrl_q;
    reg [2:0] wait_sel_q;
    reg timer_run_q;
    reg [9:0] cnt_q;
    reg [9:0] cap_q;
    reg [16:0] wait_cnt_q;
    reg [11:0] period_q;
    reg [11:0] pmax_q;
    reg [11:0] pmin_q;
    reg [11:0] pdec_q;
    reg [9:0] thresh_q;
    reg [4:0] stat_q;
    reg [4:0] stat_d;
    reg [7:0] fen_q;
    reg sfen_q;
    reg strig_q;
    reg [17:0] act_q;
    reg [1:0] fstate_q;
    reg [1:0] fcode_q;
    reg ev_prev_q;
    reg cap_prev_q;
    reg bra_prev_q;
    reg [15:0] rd_val;
    reg shut_now;
    reg [1:0] fstate_d;
    reg [1:0] fcode_d;
    reg adj_now;

    wire [1:0] small_pulse;
    wire [1:0] none_pulse;
    wire [1:0] trig = {bridge_out_b_in, bridge_out_a_in};
    wire [1:0] cmp = {current_cmp1_out_in, current_cmp0_out_in};
    // Phase output is high while voltage leads the lagging current
    wire [1:0] phase = trig & ~cmp;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            ppf_phase_det u_det (
                .mclk_in(mclk_in),
                .rst_in(rst_in),
                .trig_in(trig[ch]),
                .cmp_in(cmp[ch]),
                .phase_in(phase[ch]),
                .thresh_in(thresh_q),
                .small_out(small_pulse[ch]),
                .none_out(none_pulse[ch])
            );
        end
    endgenerate

    wire wr_ctrl = wr_in && (addr_in == `PPF_A_CTRL);
    wire wr_tctrl = wr_in && (addr_in == `PPF_A_TCTRL);
    wire wr_period = wr_in && (addr_in == `PPF_A_PERIOD);
    wire wr_stat = wr_in && (addr_in == `PPF_A_STATUS);

    // Event clock source and edge detect
    wire ev_clk = ctrl_q[`PPF_C_SRC] ? current_cmp1_out_in
                                     : current_cmp0_out_in;
    wire ev_rise = ev_clk & ~ev_prev_q;
    wire cap_in = ctrl_q[`PPF_C_PHSEL] ? phase[1] : phase[0];
    wire [1:0] edge_sel = ctrl_q[`PPF_C_EDGE_LO+1:`PPF_C_EDGE_LO];
    wire cap_rise = cap_in & ~cap_prev_q;
    wire cap_fall = ~cap_in & cap_prev_q;
    wire cap_edge = (edge_sel == 2'h0) ? cap_rise :
                    (edge_sel == 2'h1) ? cap_fall : (cap_rise | cap_fall);
    wire [16:0] wait_len = WAIT_BASE_CYCLES << wait_sel_q;
    wire timer_start = wr_tctrl && wdata_in[`PPF_T_RUN] && !timer_run_q;
    wire capm = ctrl_q[`PPF_C_CAPM];
    wire win_end = timer_run_q && !capm && !timer_start &&
                   (wait_cnt_q == wait_len - 17'h0_0001);
    wire cap_hit = timer_run_q && capm && !timer_start && cap_edge;

    // Fault sources and priority
    wire [8:0] src = {strig_q, fault_cmp_out_in, phase_protect_irq_out};
    wire [8:0] src_en = src & {sfen_q, fen_q};
    wire f_any;
    wire [1:0] f_code;
    ppf_fault_prio u_prio (
        .active_in(src_en),
        .sel_in(act_q),
        .any_out(f_any),
        .code_out(f_code)
    );

    wire period_end = bridge_out_a_in & ~bra_prev_q;
    wire [11:0] adj_period = period_q - pdec_q;
    wire adj_ok = (period_q >= pdec_q) && (adj_period >= pmin_q);
    wire adjusting = (fstate_q == S_RUN) && fcode_q[1];
    wire over_max = ctrl_q[`PPF_C_LIMEN] && (wdata_in[11:0] > pmax_q);
    wire period_take = wr_period && !over_max && !adjusting;

    // Status flags: hardware set wins over a software clear in one cycle
    always @* begin
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = stat_q & wdata_in[4:0];
        end
        if (win_end || cap_hit) begin
            stat_d[`PPF_S_CAP] = 1'b1;
        end
        if (wr_period && over_max) begin
            stat_d[`PPF_S_VIOL] = 1'b1;
        end
        if (|small_pulse) begin
            stat_d[`PPF_S_SMALL] = 1'b1;
        end
        if (|none_pulse) begin
            stat_d[`PPF_S_NONE] = 1'b1;
        end
        if (shut_now) begin
            stat_d[`PPF_S_FSD] = 1'b1;
        end
    end

    // Fault action sequencing
    always @* begin
        fstate_d = fstate_q;
        fcode_d = fcode_q;
        shut_now = 1'b0;
        adj_now = 1'b0;
        case (fstate_q)
            S_IDLE: begin
                if (f_any) begin
                    fstate_d = S_RUN;
                    fcode_d = f_code;
                end
            end
            S_RUN: begin
                if (f_any && (f_code < fcode_q)) begin
                    fcode_d = f_code;
                end else begin
                    case (fcode_q)
                        `PPF_ACT_SHUT: begin
                            shut_now = 1'b1;
                            fstate_d = S_IDLE;
                        end
                        `PPF_ACT_SHUT_END: begin
                            if (period_end) begin
                                shut_now = 1'b1;
                                fstate_d = S_IDLE;
                            end
                        end
                        default: begin
                            if (period_end) begin
                                if (adj_ok) begin
                                    adj_now = 1'b1;
                                end else begin
                                    shut_now = ~fcode_q[0];
                                    fstate_d = S_IDLE;
                                end
                            end
                        end
                    endcase
                end
            end
            default: fstate_d = S_IDLE;
        endcase
    end

    // Register file writes and timer
    always @(posedge mclk_in) begin
        if (rst_in) begin
            ctrl_q <= {`PPF_CTRL_W{1'b0}};
            wait_sel_q <= 3'h0;
            timer_run_q <= 1'b0;
            cnt_q <= 10'h000;
            cap_q <= 10'h000;
            wait_cnt_q <= 17'h0_0000;
            period_q <= `PPF_PERIOD_RST;
            pmax_q <= `PPF_PMAX_RST;
            pmin_q <= `PPF_PMIN_RST;
            pdec_q <= `PPF_PDEC_RST;
            thresh_q <= `PPF_THRESH_RST;
            stat_q <= 5'h00;
            fen_q <= 8'h00;
            sfen_q <= 1'b0;
            strig_q <= 1'b0;
            act_q <= 18'h0_0000;
            fstate_q <= S_IDLE;
            fcode_q <= `PPF_ACT_SHUT;
            ev_prev_q <= 1'b0;
            cap_prev_q <= 1'b0;
            bra_prev_q <= 1'b0;
        end else begin
            ev_prev_q <= ev_clk;
            cap_prev_q <= cap_in;
            bra_prev_q <= bridge_out_a_in;
            stat_q <= stat_d;
            fstate_q <= fstate_d;
            fcode_q <= fcode_d;
            if (wr_ctrl) begin
                ctrl_q <= wdata_in[`PPF_CTRL_W-1:0];
            end
            if (shut_now) begin
                ctrl_q[`PPF_C_RUN] <= 1'b0;
            end
            if (wr_tctrl) begin
                wait_sel_q <= wdata_in[2:0];
                timer_run_q <= wdata_in[`PPF_T_RUN];
            end
            if (timer_start) begin
                // Only a rising run bit resets the count
                cnt_q <= 10'h000;
                wait_cnt_q <= 17'h0_0000;
            end else if (timer_run_q) begin
                if (capm) begin
                    cnt_q <= cnt_q + 10'h001;
                    if (cap_edge) begin
                        cap_q <= cnt_q;
                    end
                end else begin
                    if (ev_rise) begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                    wait_cnt_q <= wait_cnt_q + 17'h0_0001;
                    if (win_end) begin
                        cap_q <= cnt_q;
                        timer_run_q <= 1'b0;
                    end
                end
            end
            if (period_take) begin
                period_q <= wdata_in[11:0];
            end else if (adj_now) begin
                period_q <= adj_period;
            end
            if (wr_in && (addr_in == `PPF_A_PMAX)) begin
                pmax_q <= wdata_in[11:0];
            end
            if (wr_in && (addr_in == `PPF_A_PMIN) && !adjusting) begin
                pmin_q <= wdata_in[11:0];
            end
            if (wr_in && (addr_in == `PPF_A_PDEC) && !adjusting) begin
                pdec_q <= wdata_in[11:0];
            end
            if (wr_in && (addr_in == `PPF_A_THRESH)) begin
                thresh_q <= wdata_in[9:0];
            end
            if (wr_in && (addr_in == `PPF_A_FEN)) begin
                fen_q <= wdata_in[7:0];
                sfen_q <= wdata_in[`PPF_F_SEN];
                strig_q <= wdata_in[`PPF_F_STRIG];
            end
            // Selectors change only while no protect action runs
            if (wr_in && (addr_in == `PPF_A_ACT0) && fstate_q == S_IDLE) begin
                act_q[7:0] <= wdata_in[7:0];
            end
            if (wr_in && (addr_in == `PPF_A_ACT1) && fstate_q == S_IDLE) begin
                act_q[15:8] <= wdata_in[7:0];
            end
            if (wr_in && (addr_in == `PPF_A_ACT2) && fstate_q == S_IDLE) begin
                act_q[17:16] <= wdata_in[1:0];
            end
        end
    end

    // Read decode
    always @* begin
        if (addr_in == `PPF_A_CTRL) begin
            rd_val = {9'h000, ctrl_q};
        end else if (addr_in == `PPF_A_TCTRL) begin
            rd_val = {12'h000, timer_run_q, wait_sel_q};
        end else if (addr_in == `PPF_A_CAPTURE) begin
            rd_val = {6'h00, cap_q};
        end else if (addr_in == `PPF_A_PERIOD) begin
            rd_val = {4'h0, period_q};
        end else if (addr_in == `PPF_A_PMAX) begin
            rd_val = {4'h0, pmax_q};
        end else if (addr_in == `PPF_A_THRESH) begin
            rd_val = {6'h00, thresh_q};
        end else if (addr_in == `PPF_A_STATUS) begin
            rd_val = {11'h000, stat_q};
        end else if (addr_in == `PPF_A_FEN) begin
            rd_val = {6'h00, strig_q, sfen_q, fen_q};
        end else if (addr_in == `PPF_A_ACT0) begin
            rd_val = {8'h00, act_q[7:0]};
        end else if (addr_in == `PPF_A_ACT1) begin
            rd_val = {8'h00, act_q[15:8]};
        end else if (addr_in == `PPF_A_ACT2) begin
            rd_val = {14'h0000, act_q[17:16]};
        end else if (addr_in == `PPF_A_PMIN) begin
            rd_val = {4'h0, pmin_q};
        end else if (addr_in == `PPF_A_PDEC) begin
            rd_val = {4'h0, pdec_q};
        end else if (addr_in == `PPF_A_FSTATE) begin
            rd_val = {12'h000, fcode_q, fstate_q};
        end else begin
            rd_val = 16'h0000;
        end
    end

    // Outputs, all registered
    always @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_out <= 16'h0000;
            pwm_period_out <= `PPF_PERIOD_RST;
            pwm_run_out <= 1'b0;
            pwm_safe_out <= 1'b0;
            capture_irq_out <= 1'b0;
            phase_protect_irq_out <= 1'b0;
            fault_irq_out <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rd_val : 16'h0000;
            pwm_period_out <= period_take ? wdata_in[11:0] :
                              adj_now ? adj_period : period_q;
            pwm_run_out <= ctrl_q[`PPF_C_RUN] & ~shut_now;
            // Safe level holds until software restarts the bridge
            if (shut_now) begin
                pwm_safe_out <= 1'b1;
            end else if (wr_ctrl && wdata_in[`PPF_C_RUN]) begin
                pwm_safe_out <= 1'b0;
            end
            capture_irq_out <= stat_d[`PPF_S_CAP];
            phase_protect_irq_out <= stat_d[`PPF_S_SMALL] |
                                     stat_d[`PPF_S_NONE];
            fault_irq_out <= |src_en;
        end
    end
endmodule

// [common/ppf_consts.vh]
// Register map, field positions, reset values and codes of the phase protect block
`ifndef PPF_CONSTS_VH
`define PPF_CONSTS_VH

`define PPF_AW 4
`define PPF_DW 16
`define PPF_A_CTRL 4'h0
`define PPF_A_TCTRL 4'h1
`define PPF_A_CAPTURE 4'h2
`define PPF_A_PERIOD 4'h3
`define PPF_A_PMAX 4'h4
`define PPF_A_THRESH 4'h5
`define PPF_A_STATUS 4'h6
`define PPF_A_FEN 4'h7
`define PPF_A_ACT0 4'h8
`define PPF_A_ACT1 4'h9
`define PPF_A_ACT2 4'ha
`define PPF_A_PMIN 4'hb
`define PPF_A_PDEC 4'hc
`define PPF_A_FSTATE 4'hd

// Control register fields
`define PPF_C_SRC 0
`define PPF_C_LIMEN 1
`define PPF_C_RUN 2
`define PPF_C_CAPM 3
`define PPF_C_EDGE_LO 4
`define PPF_C_PHSEL 6
`define PPF_CTRL_W 7
// Timer control fields
`define PPF_T_RUN 3
// Status fields
`define PPF_S_CAP 0
`define PPF_S_VIOL 1
`define PPF_S_SMALL 2
`define PPF_S_NONE 3
`define PPF_S_FSD 4
// Fault enable register fields
`define PPF_F_SEN 8
`define PPF_F_STRIG 9

`define PPF_PERIOD_RST 12'h01f3
`define PPF_PMAX_RST 12'h0fff
`define PPF_PMIN_RST 12'h0190
`define PPF_PDEC_RST 12'h001e
`define PPF_THRESH_RST 10'h000
`define PPF_WAIT_BASE 17'h0_0100

// Protect action codes, lower code wins
`define PPF_ACT_SHUT 2'h0
`define PPF_ACT_SHUT_END 2'h1
`define PPF_ACT_ADJ_SHUT 2'h2
`define PPF_ACT_ADJ 2'h3

`endif

// [src/ppf_phase_det.v]
// Per-channel phase width check over one bridge-output detection period
`timescale 1ns/1ps
`include "ppf_consts.vh"
module ppf_phase_det (
    input wire mclk_in,
    input wire rst_in,
    input wire trig_in,
    input wire cmp_in,
    input wire phase_in,
    input wire [9:0] thresh_in,
    output reg small_out,
    output reg none_out
);
    reg trig_prev_q;
    reg phase_prev_q;
    reg seen_q;
    reg meas_q;
    reg [9:0] width_q;
    wire trig_rise = trig_in & ~trig_prev_q;
    wire ph_rise = phase_in & ~phase_prev_q;
    wire ph_fall = ~phase_in & phase_prev_q;

    always @(posedge mclk_in) begin
        if (rst_in) begin
            trig_prev_q <= 1'b0;
            phase_prev_q <= 1'b0;
            seen_q <= 1'b1;
            meas_q <= 1'b0;
            width_q <= 10'h000;
            small_out <= 1'b0;
            none_out <= 1'b0;
        end else begin
            trig_prev_q <= trig_in;
            phase_prev_q <= phase_in;
            small_out <= 1'b0;
            none_out <= 1'b0;
            if (trig_rise) begin
                // Closes a period and opens the next, pulse included
                none_out <= ~seen_q & ~cmp_in;
                seen_q <= ph_rise;
                meas_q <= ph_rise;
                width_q <= 10'h001;
            end else if (ph_rise && !seen_q) begin
                // Later pulses of this period are never measured
                seen_q <= 1'b1;
                meas_q <= 1'b1;
                width_q <= 10'h001;
            end else if (meas_q) begin
                if (ph_fall) begin
                    meas_q <= 1'b0;
                    small_out <= (width_q < thresh_in);
                end else if (width_q != 10'h3ff) begin
                    width_q <= width_q + 10'h001;
                end
            end
        end
    end
endmodule

// [src/ppf_fault_prio.v]
// Picks the highest-priority action code among active fault sources
`timescale 1ns/1ps
`include "ppf_consts.vh"
module ppf_fault_prio (
    input wire [8:0] active_in,
    input wire [17:0] sel_in,
    output wire any_out,
    output wire [1:0] code_out
);
    wire [8:0] has0;
    wire [8:0] has1;
    wire [8:0] has2;
    genvar i;
    generate
        for (i = 0; i < 9; i = i + 1) begin : g_src
            assign has0[i] = active_in[i] & (sel_in[2*i+1:2*i] == 2'h0);
            assign has1[i] = active_in[i] & (sel_in[2*i+1:2*i] == 2'h1);
            assign has2[i] = active_in[i] & (sel_in[2*i+1:2*i] == 2'h2);
        end
    endgenerate
    assign any_out = |active_in;
    // Code 00 beats 01 beats 10 beats 11
    assign code_out = (|has0) ? `PPF_ACT_SHUT :
                      (|has1) ? `PPF_ACT_SHUT_END :
                      (|has2) ? `PPF_ACT_ADJ_SHUT : `PPF_ACT_ADJ;
endmodule

// [dv/ppf_monitor.sv]
// Port-level checker for the phase protect block
`timescale 1ns/1ps
`include "ppf_consts.vh"
module ppf_monitor #(
    parameter [16:0] WAIT_BASE_CYCLES = `PPF_WAIT_BASE
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [6:0] fault_cmp_out_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic [11:0] pwm_period_out,
    input wire logic pwm_run_out,
    input wire logic pwm_safe_out,
    input wire logic capture_irq_out,
    input wire logic phase_protect_irq_out,
    input wire logic fault_irq_out
);
    localparam int LO = WAIT_BASE_CYCLES - 3;
    localparam int HI = WAIT_BASE_CYCLES + 3;
    // Shadows of software-written bits; hardware can still clear the control run bit and the timer run bit
    logic [3:0] ctrl_q;
    logic [11:0] pmax_q;
    logic [9:0] fen_q;
    logic trun_q;
    wire st_wr = wr_in && addr_in == `PPF_A_STATUS;
    wire per_bad = wr_in && addr_in == `PPF_A_PERIOD && ctrl_q[1]
        && wdata_in[11:0] > pmax_q;
    wire fsrc = |(fen_q[7:0] & {fault_cmp_out_in, phase_protect_irq_out})
        || (fen_q[8] && fen_q[9]);
    always @(posedge mclk_in) begin
        if (rst_in) begin
            ctrl_q <= 4'h0;
            pmax_q <= `PPF_PMAX_RST;
            fen_q <= 10'h000;
            trun_q <= 1'b0;
        end else if (wr_in) begin
            case (addr_in)
                `PPF_A_CTRL: ctrl_q <= wdata_in[3:0];
                `PPF_A_PMAX: pmax_q <= wdata_in[11:0];
                `PPF_A_FEN: fen_q <= wdata_in[9:0];
                `PPF_A_TCTRL: trun_q <= wdata_in[3];
                default: ;
            endcase
        end
    end
    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // Count mode start with the shortest window and a clear flag
    sequence s_tstart;
        wr_in && addr_in == `PPF_A_TCTRL && wdata_in[3] && !trun_q
            && wdata_in[2:0] == 3'h0 && !ctrl_q[3] && !capture_irq_out;
    endsequence
    sequence s_window;
        !capture_irq_out [*3] ##[LO:HI] capture_irq_out;
    endsequence
    a_wait_window: assert property (s_tstart |=> s_window)
        else $error("capture flag not raised at window end");
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside read slot");
    a_unmapped_read: assert property
        (rd_in && addr_in > `PPF_A_FSTATE |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_phase_flag_hold: assert property (phase_protect_irq_out ##1
        !phase_protect_irq_out |-> $past(st_wr, 1) || $past(st_wr, 2))
        else $error("phase interrupt fell without status write");
    a_fault_irq_on: assert property (fsrc [*4] |-> fault_irq_out)
        else $error("enabled fault source did not raise fault irq");
    a_fault_irq_off: assert property (!fsrc [*4] |-> !fault_irq_out)
        else $error("fault irq without enabled source");
    a_safe_not_run: assert property (pwm_safe_out |-> !pwm_run_out)
        else $error("bridge safe while run set");
    a_period_guard: assert property (per_bad |=> $stable(pwm_period_out))
        else $error("period above limit accepted");
    cover property (s_tstart);
endmodule

// [dv/ppf_bridge_model.sv]
// Behavioural bridge PWM generator and current comparators
`timescale 1ns/1ps
module ppf_bridge_model (
    input wire logic mclk_in,
    input wire logic en_in,
    input wire logic only_a_in,
    input wire logic cmp_hi_in,
    input wire logic [3:0] half_in,
    input wire logic [3:0] lag_in,
    output logic bridge_a_out,
    output logic bridge_b_out,
    output logic cmp0_out,
    output logic cmp1_out
);
    logic [4:0] cnt_q = 5'h00;
    logic [15:0] ha_q = 16'h0000;
    logic [15:0] hb_q = 16'h0000;
    // Current lags voltage by lag_in cycles; cmp_hi_in models a leading one
    always @(posedge mclk_in) begin
        if (!en_in || cnt_q == {half_in, 1'b0} - 5'h01)
            cnt_q <= 5'h00;
        else
            cnt_q <= cnt_q + 5'h01;
        ha_q <= {ha_q[14:0], bridge_a_out};
        hb_q <= {hb_q[14:0], bridge_b_out};
    end
    always @* begin
        bridge_a_out = en_in && cnt_q < {1'b0, half_in};
        bridge_b_out = en_in && !only_a_in && cnt_q >= {1'b0, half_in};
        cmp0_out = cmp_hi_in || ha_q[lag_in - 4'h1];
        cmp1_out = cmp_hi_in || hb_q[lag_in - 4'h1];
    end
endmodule

// [dv/ppf_top_tb_top.sv]
// Self-checking bench for the phase protect block
`timescale 1ns/1ps
`include "ppf_consts.vh"
module ppf_top_tb_top;
    localparam logic [3:0] CT = `PPF_A_CTRL, TC = `PPF_A_TCTRL,
        ST = `PPF_A_STATUS, PER = `PPF_A_PERIOD, FE = `PPF_A_FEN;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [6:0] fcmp = 7'h00;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic en = 1'b0;
    logic only_a = 1'b0;
    logic cmp_hi = 1'b0;
    logic [3:0] half = 4'h4;
    logic [3:0] lag = 4'h2;
    logic [15:0] v;
    logic [15:0] v2;
    wire cmp0, cmp1, br_a, br_b, run, safe, cap_irq, ph_irq, f_irq;
    wire [15:0] rdata;
    wire [11:0] period;
    int miscompares = 0;
    int check_count = 0;
    initial forever #50 mclk_in = ~mclk_in;
    ppf_bridge_model ppf_bridge_model_i (.mclk_in(mclk_in), .en_in(en),
        .only_a_in(only_a), .cmp_hi_in(cmp_hi), .half_in(half),
        .lag_in(lag), .bridge_a_out(br_a), .bridge_b_out(br_b),
        .cmp0_out(cmp0), .cmp1_out(cmp1));
    ppf_top #(.WAIT_BASE_CYCLES(17'h0_0004)) ppf_top_i (.mclk_in(mclk_in),
        .rst_in(rst_in), .current_cmp0_out_in(cmp0),
        .current_cmp1_out_in(cmp1), .fault_cmp_out_in(fcmp),
        .bridge_out_a_in(br_a), .bridge_out_b_in(br_b), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata), .pwm_period_out(period), .pwm_run_out(run),
        .pwm_safe_out(safe), .capture_irq_out(cap_irq),
        .phase_protect_irq_out(ph_irq), .fault_irq_out(f_irq));
    task automatic chk(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic w(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic r(input string n, input logic [3:0] a,
        input logic [15:0] m, e);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 v = rdata;
        chk(n, v & m, e);
    endtask
    task automatic wait_cap;
        for (int i = 0; i < 300 && cap_irq !== 1'b1; i++) cyc(1);
        #1;
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        miscompares++;
        complete_run();
    end
    initial begin
        cyc(10);
        rst_in <= 1'b0;
        chk("period out", 16'(period), 16'h01f3);
        r("period", PER, 16'hffff, 16'h01f3);
        r("limit", `PPF_A_PMAX, 16'hffff, 16'h0fff);
        r("min", `PPF_A_PMIN, 16'hffff, 16'h0190);
        r("dec", `PPF_A_PDEC, 16'hffff, 16'h001e);
        r("status", ST, 16'hffff, 16'h0000);
        r("unmapped", 4'he, 16'hffff, 16'h0000);
        w(TC, 16'h0008);
        wait_cap();
        r("timer run", TC, 16'h0008, 16'h0000);
        only_a <= 1'b1;
        half <= 4'h2;
        lag <= 4'h1;
        for (int s = 0; s < 2; s++) begin
            w(ST, 16'h0000);
            w(CT, 16'(s));
            w(TC, 16'h0000);
            w(TC, 16'h000b);
            en <= 1'b1;
            cyc(12);
            en <= 1'b0;
            wait_cap();
            chk("cap irq", 16'(cap_irq), 16'h0001);
            r("events", `PPF_A_CAPTURE, 16'hffff, s ? 16'h0 : 16'h3);
        end
        w(ST, 16'h0000);
        w(`PPF_A_PMAX, 16'h0300);
        w(CT, 16'h0002);
        w(PER, 16'h0301);
        chk("period kept", 16'(period), 16'h01f3);
        r("limit flag", ST, 16'h0002, 16'h0002);
        w(PER, 16'h0300);
        chk("period at limit", 16'(period), 16'h0300);
        w(CT, 16'h0000);
        w(PER, 16'h0400);
        chk("period free", 16'(period), 16'h0400);
        w(`PPF_A_THRESH, 16'h0005);
        only_a <= 1'b0;
        half <= 4'h8;
        lag <= 4'h2;
        en <= 1'b1;
        cyc(80);
        chk("phase irq", 16'(ph_irq), 16'h0001);
        r("small flag", ST, 16'h000c, 16'h0004);
        w(FE, 16'h0001);
        cyc(4);
        chk("phase fault", 16'(f_irq), 16'h0001);
        w(FE, 16'h0000);
        en <= 1'b0;
        cyc(40);
        w(ST, 16'hffff);
        r("flag held", ST, 16'h000c, 16'h0004);
        w(ST, 16'h0000);
        cyc(4);
        chk("irq cleared", 16'(ph_irq), 16'h0000);
        w(ST, 16'hffff);
        r("no soft set", ST, 16'h001f, 16'h0000);
        lag <= 4'h8;
        half <= 4'hc;
        for (int k = 0; k < 2; k++) begin
            cmp_hi <= k[0];
            en <= 1'b1;
            cyc(60);
            w(ST, 16'h0000);
            cyc(80);
            r("no phase flags", ST, 16'h000c, 16'h0000);
        end
        w(CT, 16'h0008);
        w(TC, 16'h0000);
        w(TC, 16'h0008);
        w(ST, 16'h0000);
        cmp_hi <= 1'b0;
        lag <= 4'h2;
        half <= 4'h4;
        cyc(40);
        chk("capture irq", 16'(cap_irq), 16'h0001);
        r("none flag", ST, 16'h0008, 16'h0008);
        r("cap a", `PPF_A_CAPTURE, 16'hfc00, 16'h0000);
        v2 = v;
        cyc(21);
        r("cap b", `PPF_A_CAPTURE, 16'hfc00, 16'h0000);
        chk("capture step", (v - v2) & 16'h0007, 16'h0000);
        chk("free run", 16'(v != v2), 16'h0001);
        cmp_hi <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            w(FE, 16'h0000);
            cyc(20);
            en <= 1'b0;
            w(ST, 16'h0000);
            w(PER, 16'h01f3);
            w(`PPF_A_ACT2, 16'(c));
            w(CT, 16'h0004);
            cyc(2);
            chk("run on", 16'(run), 16'h0001);
            w(FE, 16'h0300);
            cyc(3);
            chk("early safe", 16'(safe), 16'(c == 0));
            chk("soft fault", 16'(f_irq), 16'h0001);
            en <= 1'b1;
            cyc(64);
            chk("run", 16'(run), 16'(c == 3));
            chk("safe", 16'(safe), 16'(c != 3));
            chk("period", 16'(period), c > 1 ? 16'h0199 : 16'h01f3);
            r("shut flag", ST, 16'h0010, c == 3 ? 16'h0 : 16'h10);
        end
        for (int p = 0; p < 2; p++) begin
            fcmp <= 7'h00;
            w(FE, 16'h0000);
            cyc(20);
            en <= 1'b0;
            w(PER, 16'h01f3);
            w(CT, 16'h0004);
            w(`PPF_A_ACT0, p ? 16'h000c : 16'h001c);
            w(FE, 16'h0006);
            fcmp <= p ? 7'h01 : 7'h03;
            en <= 1'b1;
            cyc(20);
            chk("prio safe", 16'(safe), 16'(p == 0));
            chk("prio period", 16'(period == 12'h1f3), 16'(p == 0));
        end
        en <= 1'b0;
        fcmp <= 7'h03;
        cyc(3);
        chk("preempt safe", 16'(safe), 16'h0001);
        chk("preempt run", 16'(run), 16'h0000);
        complete_run();
    end
endmodule
bind ppf_top ppf_monitor #(.WAIT_BASE_CYCLES(WAIT_BASE_CYCLES)) ppf_monitor_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .fault_cmp_out_in(fault_cmp_out_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pwm_period_out(pwm_period_out),
    .pwm_run_out(pwm_run_out), .pwm_safe_out(pwm_safe_out),
    .capture_irq_out(capture_irq_out),
    .phase_protect_irq_out(phase_protect_irq_out),
    .fault_irq_out(fault_irq_out));
